//--- pkg/irq_router_regs.svh
// constants for the legacy and serialized interrupt router
//
// Behaviour
// - slave levels 8-15 cascade onto master level 2
// - one combined processor interrupt in legacy mode
// - per-source selectable APIC input routing table
// - fixed onboard and rotated slot PCI wiring
// - APIC mode sends message per incoming interrupt
// - more than sixteen APIC levels delivered
// - frame is start, >=17 slots, stop
// - continuous mode: only host starts frames
// - receiver accepts up to 32 channels
// - external serializer carries sixteen PCI lines
// - recommended legacy map; software may remap
`ifndef IRQ_ROUTER_REGS_SVH
`define IRQ_ROUTER_REGS_SVH

// serial frame timing, in clocks
`define SERIRQ_START_CLKS 4'h6
`define SERIRQ_STOP_QUIET 4'h2
`define SERIRQ_STOP_CONT 4'h3
`define SERIRQ_REST_CLKS 4'h2
`define SERIRQ_SLOT_PHASES 2'h3
`define SERIRQ_MIN_SLOTS 17
`define SERIRQ_MAX_SLOTS 32

// onboard PCI input numbers
`define PCI_IN_SCSI_A 4'h0
`define PCI_IN_SCSI_B 4'h1
`define PCI_IN_NIC1 4'h2
`define PCI_IN_NIC2 4'h3
`define PCI_IN_VIDEO 4'h4
// slot INTA-INTD to PCI input, nibble (slot-1)*4+pin, slots 1..6
`define SLOT_PIN_MAP 96'h01babdc9cbd8dcb7bdc6cbd5

// recommended legacy levels
`define IRQ_KEYBOARD 4'h1
`define IRQ_SERIAL_A 4'h3
`define IRQ_SERIAL_B 4'h4
`define IRQ_FLOPPY 4'h6
`define IRQ_RTC 4'h8
`define IRQ_MOUSE 4'hc
`define IRQ_IDE_PRIMARY 4'he
`define PIC_CASCADE_LEVEL 3'h2

// APIC serial message
`define APIC_MSG_PAIRS 2'h3
`define APIC_SOURCES 32

`endif

//--- pkg/irq_router_pkg.sv
// types shared by the interrupt router modules
package irq_router_pkg;

   typedef enum logic [2:0] {
      FR_IDLE = 3'b000,
      FR_START = 3'b001,
      FR_TURN = 3'b010,
      FR_SLOT = 3'b011,
      FR_STOP = 3'b100,
      FR_REST = 3'b101
   } frame_state_t;

endpackage

//--- pkg/frame_if.sv
// link between the router core and one serial frame engine
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
   logic line_in;
   logic continuous;
   logic drive_n;
   logic [31:0] channels;
   logic frame_done;

   modport engine (input line_in, input continuous, output drive_n, output channels,
      output frame_done);
   modport user (output line_in, output continuous, input drive_n, input channels,
      input frame_done);
endinterface
`default_nettype wire

//--- verilog/serirq_frame_engine.sv
// serialized interrupt frame engine: start, slot sampling and stop
`timescale 1ns/1ps
`default_nettype none
`include "irq_router_regs.svh"
module serirq_frame_engine #(
   parameter int NUM_SLOTS = `SERIRQ_MIN_SLOTS
) (
   input wire logic clock,
   input wire logic nrst,
   frame_if.engine f
);
   irq_router_pkg::frame_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [1:0] phase_reg;
   logic [5:0] slot_reg;
   logic drive_n_reg;
   logic done_reg;
   logic [31:0] chan_reg;

   assign f.drive_n = drive_n_reg;
   assign f.channels = chan_reg;
   assign f.frame_done = done_reg;

   // frame sequencing; the host always drives the stop frame
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= irq_router_pkg::FR_IDLE;
         cnt_reg <= 4'h0;
         phase_reg <= 2'h0;
         slot_reg <= 6'h00;
         drive_n_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         unique case (state_reg)
            irq_router_pkg::FR_IDLE: begin
               if (f.continuous) begin
                  state_reg <= irq_router_pkg::FR_START;
                  drive_n_reg <= 1'b0;
                  cnt_reg <= `SERIRQ_START_CLKS - 4'h1;
               end else if (!f.line_in) begin
                  // slave drove the first start clock, host holds the rest
                  state_reg <= irq_router_pkg::FR_START;
                  drive_n_reg <= 1'b0;
                  cnt_reg <= `SERIRQ_START_CLKS - 4'h2;
               end
            end
            irq_router_pkg::FR_START: begin
               if (cnt_reg == 4'h0) begin
                  drive_n_reg <= 1'b1;
                  state_reg <= irq_router_pkg::FR_TURN;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            irq_router_pkg::FR_TURN: begin
               state_reg <= irq_router_pkg::FR_SLOT;
               phase_reg <= 2'h0;
               slot_reg <= 6'h00;
            end
            irq_router_pkg::FR_SLOT: begin
               if (phase_reg == `SERIRQ_SLOT_PHASES - 2'h1) begin
                  phase_reg <= 2'h0;
                  if (slot_reg == 6'(NUM_SLOTS - 1)) begin
                     state_reg <= irq_router_pkg::FR_STOP;
                     drive_n_reg <= 1'b0;
                     // stop width tells slaves which mode follows
                     cnt_reg <= (f.continuous ? `SERIRQ_STOP_CONT : `SERIRQ_STOP_QUIET)
                        - 4'h1;
                  end else begin
                     slot_reg <= slot_reg + 6'h01;
                  end
               end else begin
                  phase_reg <= phase_reg + 2'h1;
               end
            end
            irq_router_pkg::FR_STOP: begin
               if (cnt_reg == 4'h0) begin
                  drive_n_reg <= 1'b1;
                  state_reg <= irq_router_pkg::FR_REST;
                  cnt_reg <= `SERIRQ_REST_CLKS - 4'h1;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            irq_router_pkg::FR_REST: begin
               // recovery gap keeps a released line from reading as a new start
               if (cnt_reg == 4'h0) begin
                  state_reg <= irq_router_pkg::FR_IDLE;
                  done_reg <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= irq_router_pkg::FR_IDLE;
               drive_n_reg <= 1'b1;
            end
         endcase
      end
   end

   // one sample per slot in its first phase, low means request
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         chan_reg <= 32'h0000_0000;
      end else if (state_reg == irq_router_pkg::FR_SLOT && phase_reg == 2'h0) begin
         chan_reg[slot_reg[4:0]] <= ~f.line_in;
      end
   end

endmodule
`default_nettype wire

//--- verilog/legacy_serial_irq_router.sv
// interrupt router: cascaded legacy controllers, serial IRQ and APIC messages
`timescale 1ns/1ps
`default_nettype none
`include "irq_router_regs.svh"
module legacy_serial_irq_router #(
   parameter int NUM_SLOTS = `SERIRQ_MIN_SLOTS
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic continuous_mode,
   input wire logic apic_mode,
   input wire logic serirq_in,
   output logic serirq_out,
   output logic serirq_oe_n,
   input wire logic pci_irq_scan_lines,
   output logic pci_scan_out,
   output logic pci_scan_oe_n,
   input wire logic rtc_alarm_request_n,
   input wire logic video_int,
   input wire logic nic1_int,
   input wire logic nic2_int,
   input wire logic scsi_a_int,
   input wire logic scsi_b_int,
   input wire logic [23:0] slot_int,
   input wire logic [15:0] legacy_mask,
   input wire logic intack,
   input wire logic eoi,
   output logic intr,
   output logic [3:0] int_vector,
   input wire logic cfg_wr,
   input wire logic [4:0] cfg_src,
   input wire logic [4:0] cfg_dest,
   output logic apic_clk,
   output logic apic_d0_out,
   output logic apic_d0_oe_n,
   output logic apic_d1_out,
   output logic apic_d1_oe_n
);
   localparam logic [95:0] SLOT_MAP = `SLOT_PIN_MAP;

   frame_if ser_if ();
   frame_if scan_if ();

   logic low_reg;
   logic [4:0] route_reg [0:`APIC_SOURCES-1];
   logic [31:0] apic_prev_reg;
   logic [31:0] pending_reg;
   logic apic_clk_reg;
   logic busy_reg;
   logic [1:0] pair_reg;
   logic [5:0] shift_reg;
   logic d0_oe_n_reg;
   logic d1_oe_n_reg;
   logic intr_reg;
   logic [3:0] vector_reg;
   logic [15:0] in_service_reg;

   logic [15:0] wired;
   logic [15:0] pci_lines;
   logic [15:0] legacy;
   logic [31:0] sources;
   logic [31:0] apic_in;
   logic take;
   logic [4:0] pick;
   logic [31:0] sent_mask;
   logic [15:0] req;
   logic [7:0] prim;
   logic [3:0] chosen;

   // both serial lines share one engine design
   assign ser_if.line_in = serirq_in;
   assign ser_if.continuous = continuous_mode;
   assign scan_if.line_in = pci_irq_scan_lines;
   assign scan_if.continuous = continuous_mode;

   serirq_frame_engine #(.NUM_SLOTS(NUM_SLOTS)) u_serirq (
      .clock(clock),
      .nrst(nrst),
      .f(ser_if)
   );

   // pci lines arrive serialized from an outside shift chain
   serirq_frame_engine #(.NUM_SLOTS(NUM_SLOTS)) u_pci_scan (
      .clock(clock),
      .nrst(nrst),
      .f(scan_if)
   );

   // open-drain pins only ever pull low
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         low_reg <= 1'b0;
      end else begin
         low_reg <= 1'b0;
      end
   end

   assign serirq_out = low_reg;
   assign pci_scan_out = low_reg;
   assign apic_d0_out = low_reg;
   assign apic_d1_out = low_reg;
   assign serirq_oe_n = ser_if.drive_n;
   assign pci_scan_oe_n = scan_if.drive_n;

   // fixed board wiring folded onto the scanned pci inputs
   always_comb begin
      wired = 16'h0000;
      wired[`PCI_IN_VIDEO] = video_int;
      wired[`PCI_IN_NIC1] = nic1_int;
      wired[`PCI_IN_NIC2] = nic2_int;
      wired[`PCI_IN_SCSI_A] = scsi_a_int;
      wired[`PCI_IN_SCSI_B] = scsi_b_int;
      for (int i = 0; i < 24; i++) begin
         if (slot_int[i]) begin
            wired[SLOT_MAP[i*4 +: 4]] = 1'b1;
         end
      end
   end

   // legacy levels come from serial slots 0-15, rtc also has its own pin
   always_comb begin
      pci_lines = wired | scan_if.channels[15:0];
      legacy = ser_if.channels[15:0];
      legacy[`IRQ_RTC] = ser_if.channels[`IRQ_RTC] | ~rtc_alarm_request_n;
      sources = {pci_lines, legacy};
   end

   // routing table, reset to the identity map
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < `APIC_SOURCES; i++) begin
            route_reg[i] <= 5'(i);
         end
      end else if (cfg_wr) begin
         route_reg[cfg_src] <= cfg_dest;
      end
   end

   // thirty-two apic inputs; shared routes combine as wired-or
   always_comb begin
      apic_in = 32'h0000_0000;
      for (int s = 0; s < `APIC_SOURCES; s++) begin
         if (sources[s]) begin
            apic_in[route_reg[s]] = 1'b1;
         end
      end
   end

   // lowest pending input wins the next message slot
   always_comb begin
      pick = 5'h00;
      for (int i = `APIC_SOURCES - 1; i >= 0; i--) begin
         if (pending_reg[i]) begin
            pick = 5'(i);
         end
      end
      take = apic_clk_reg && !busy_reg && (pending_reg != 32'h0000_0000);
      sent_mask = take ? (32'h0000_0001 << pick) : 32'h0000_0000;
   end

   // a rising input sets pending; a new edge beats the send clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         apic_prev_reg <= 32'h0000_0000;
         pending_reg <= 32'h0000_0000;
      end else begin
         apic_prev_reg <= apic_in;
         pending_reg <= (pending_reg & ~sent_mask)
            | (apic_mode ? (apic_in & ~apic_prev_reg) : 32'h0000_0000);
      end
   end

   // bus clock is the core clock halved and runs free
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         apic_clk_reg <= 1'b0;
      end else begin
         apic_clk_reg <= ~apic_clk_reg;
      end
   end

   assign apic_clk = apic_clk_reg;

   // start pair low, then three bit pairs, data changes on the falling bus edge
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busy_reg <= 1'b0;
         pair_reg <= 2'h0;
         shift_reg <= 6'h00;
         d0_oe_n_reg <= 1'b1;
         d1_oe_n_reg <= 1'b1;
      end else if (apic_clk_reg) begin
         if (busy_reg) begin
            if (pair_reg == `APIC_MSG_PAIRS) begin
               busy_reg <= 1'b0;
               d0_oe_n_reg <= 1'b1;
               d1_oe_n_reg <= 1'b1;
            end else begin
               d0_oe_n_reg <= shift_reg[0];
               d1_oe_n_reg <= shift_reg[1];
               shift_reg <= {2'b00, shift_reg[5:2]};
               pair_reg <= pair_reg + 2'h1;
            end
         end else if (take) begin
            busy_reg <= 1'b1;
            pair_reg <= 2'h0;
            shift_reg <= {1'b1, pick};
            d0_oe_n_reg <= 1'b0;
            d1_oe_n_reg <= 1'b0;
         end
      end
   end

   assign apic_d0_oe_n = d0_oe_n_reg;
   assign apic_d1_oe_n = d1_oe_n_reg;

   // legacy priority: primary lowest first, level 2 defers to the secondary
   always_comb begin
      req = legacy & ~legacy_mask;
      prim = {req[7:3], |req[15:8], req[1:0]};
      chosen = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         if (prim[i]) begin
            chosen = 4'(i);
         end
      end
      if (chosen[2:0] == `PIC_CASCADE_LEVEL) begin
         for (int i = 15; i >= 8; i--) begin
            if (req[i]) begin
               chosen = 4'(i);
            end
         end
      end
   end

   // single combined request; only one acknowledge takes each one
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         intr_reg <= 1'b0;
         vector_reg <= 4'h0;
         in_service_reg <= 16'h0000;
      end else begin
         intr_reg <= !apic_mode && (prim != 8'h00) && (in_service_reg == 16'h0000)
            && !(intack && intr_reg);
         if (eoi) begin
            in_service_reg <= 16'h0000;
         end
         if (intack && intr_reg) begin
            vector_reg <= chosen;
            in_service_reg <= 16'h0001 << chosen;
         end
      end
   end

   assign intr = intr_reg;
   assign int_vector = vector_reg;

endmodule
`default_nettype wire

//--- tb/irq_router_checker.sv
// assertions on the interrupt router pins
`timescale 1ns/1ps
`default_nettype none
module irq_router_checker #(
   parameter int NUM_SLOTS = 17
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic apic_mode,
   input wire logic serirq_in,
   input wire logic serirq_out,
   input wire logic serirq_oe_n,
   input wire logic pci_scan_out,
   input wire logic [15:0] legacy_mask,
   input wire logic intack,
   input wire logic intr,
   input wire logic [3:0] int_vector,
   input wire logic apic_clk,
   input wire logic apic_d0_out,
   input wire logic apic_d0_oe_n,
   input wire logic apic_d1_out,
   input wire logic apic_d1_oe_n
);
   logic oe_q;
   logic stop_next;
   // start and stop both pull the line low, so alternate on every release
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         oe_q <= 1'b1;
         stop_next <= 1'b0;
      end else begin
         oe_q <= serirq_oe_n;
         if (serirq_oe_n && !oe_q) begin
            stop_next <= !stop_next;
         end
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   chk_pins_zero: assert property (
      !serirq_out && !pci_scan_out && !apic_d0_out && !apic_d1_out)
      else $error("open-drain data driven high");
   chk_host_start: assert property (
      $fell(serirq_oe_n) && !stop_next && $past(serirq_in) |-> !serirq_oe_n [*6] ##1 serirq_oe_n)
      else $error("host start frame length wrong");
   chk_slave_start: assert property (
      $fell(serirq_oe_n) && !stop_next && !$past(serirq_in) |-> !serirq_oe_n [*5] ##1 serirq_oe_n)
      else $error("slave start frame length wrong");
   chk_stop_len: assert property (
      $fell(serirq_oe_n) && stop_next |-> !serirq_oe_n [*2] ##1
      (serirq_oe_n or (!serirq_oe_n ##1 serirq_oe_n)))
      else $error("stop frame length wrong");
   chk_apic_no_intr: assert property (apic_mode |=> !intr)
      else $error("legacy request in apic mode");
   chk_ack_drops: assert property (intr && intack |=> !intr)
      else $error("request stayed after acknowledge");
   chk_no_cascade: assert property (intr && intack |=> int_vector != 4'h2)
      else $error("cascade level acknowledged");
   chk_vector_hold: assert property (!(intr && intack) |=> $stable(int_vector))
      else $error("vector changed without acknowledge");
   chk_mask_all: assert property ((&legacy_mask) && !intr |=> !intr)
      else $error("request with all levels masked");
   chk_bus_clock: assert property ($past(nrst) |-> apic_clk != $past(apic_clk))
      else $error("bus clock did not toggle");
   chk_pair_edge: assert property (
      $changed(apic_d0_oe_n) || $changed(apic_d1_oe_n) |-> $fell(apic_clk))
      else $error("message bits moved off the falling bus clock");
endmodule
bind legacy_serial_irq_router irq_router_checker #(.NUM_SLOTS(NUM_SLOTS)) u_chk (
   .clock, .nrst, .apic_mode, .serirq_in, .serirq_out, .serirq_oe_n, .pci_scan_out,
   .legacy_mask, .intack, .intr, .int_vector, .apic_clk, .apic_d0_out, .apic_d0_oe_n,
   .apic_d1_out, .apic_d1_oe_n);
`default_nettype wire

//--- tb/serirq_slave_model.sv
// serial interrupt slave: follows frames on the wire, pulls its slots
`timescale 1ns/1ps
`default_nettype none
module serirq_slave_model #(
   parameter int NUM_SLOTS = 17
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic line,
   input wire logic kick,
   input wire logic [31:0] req,
   output logic drive_n
);
   logic [1:0] state_reg;
   logic [7:0] cnt_reg;
   // idle, start, slots, stop as seen on the wire
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= 2'h0;
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
         case (state_reg)
            2'h0: if (!line) state_reg <= 2'h1;
            2'h1: if (line) begin
               state_reg <= 2'h2;
               cnt_reg <= 8'h00;
            end
            2'h2: if (cnt_reg == 8'(3 * NUM_SLOTS - 1)) state_reg <= 2'h3;
            default: if (line) begin
               state_reg <= 2'h0;
               cnt_reg <= 8'h00;
            end
         endcase
      end
   end
   // a short idle gap before a quiet start, else the host may still be resting
   always_comb begin
      drive_n = 1'b1;
      if (state_reg == 2'h0 && kick && cnt_reg > 8'h03) drive_n = 1'b0;
      if (state_reg == 2'h2 && req[cnt_reg / 8'h03] && cnt_reg % 8'h03 != 8'h02) begin
         drive_n = 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the interrupt router
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock, nrst, continuous_mode, apic_mode, rtc_alarm_request_n;
   logic intack, eoi, cfg_wr, kick;
   logic [28:0] pci_src;
   logic [15:0] legacy_mask;
   logic [31:0] sreq, preq;
   logic [4:0] cfg_src, cfg_dest;
   wire serirq_out, serirq_oe_n, pci_scan_out, pci_scan_oe_n, intr, apic_clk;
   wire apic_d0_out, apic_d0_oe_n, apic_d1_out, apic_d1_oe_n, s_drv_n, p_drv_n;
   wire [3:0] int_vector;
   wire serirq_line, scan_line;
   int num_errors, total_checks, cycles;
   int pmap[29] = '{5, 13, 11, 12, 6, 12, 13, 11, 7, 11, 12, 13, 8, 13, 11, 12,
      9, 12, 13, 11, 10, 11, 1, 0, 4, 2, 3, 0, 1};
   int levels[6] = '{1, 3, 4, 6, 12, 14};
   // pulled-up wires: low whenever any party pulls
   assign serirq_line = (serirq_oe_n | serirq_out) & s_drv_n;
   assign scan_line = (pci_scan_oe_n | pci_scan_out) & p_drv_n;
   legacy_serial_irq_router #(.NUM_SLOTS(32)) DUT (
      .clock, .nrst, .continuous_mode, .apic_mode, .serirq_in(serirq_line), .serirq_out,
      .serirq_oe_n, .pci_irq_scan_lines(scan_line), .pci_scan_out, .pci_scan_oe_n,
      .rtc_alarm_request_n, .video_int(pci_src[24]), .nic1_int(pci_src[25]),
      .nic2_int(pci_src[26]), .scsi_a_int(pci_src[27]), .scsi_b_int(pci_src[28]),
      .slot_int(pci_src[23:0]), .legacy_mask, .intack, .eoi, .intr, .int_vector, .cfg_wr,
      .cfg_src, .cfg_dest, .apic_clk, .apic_d0_out, .apic_d0_oe_n, .apic_d1_out,
      .apic_d1_oe_n);
   serirq_slave_model #(.NUM_SLOTS(32)) slave_irq (.clock, .nrst, .line(serirq_line),
      .kick, .req(sreq), .drive_n(s_drv_n));
   serirq_slave_model #(.NUM_SLOTS(32)) slave_scan (.clock, .nrst, .line(scan_line),
      .kick(1'b0), .req(preq), .drive_n(p_drv_n));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // a hung handshake ends the run as a failure
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic reset_check();
      @(posedge clock);
      nrst <= 1'b0;
      tick(8);
      #1;
      chk({intr, serirq_oe_n, pci_scan_oe_n, apic_d0_oe_n, apic_d1_oe_n, apic_clk, int_vector},
         32'h1e0);
      @(posedge clock);
      nrst <= 1'b1;
   endtask
   // a frame is over 100 clocks, so wait two before acting on a level
   task automatic legacy_case(input logic [16:0] lv, input logic [15:0] m, input logic [4:0] e);
      @(posedge clock);
      sreq <= {16'h0000, lv[15:0]};
      rtc_alarm_request_n <= !lv[16];
      legacy_mask <= m;
      tick(240);
      #1;
      chk(intr, !e[4]);
      if (!e[4]) begin
         @(posedge clock);
         intack <= 1'b1;
         @(posedge clock);
         intack <= 1'b0;
         #1;
         chk({intr, int_vector}, {1'b0, e[3:0]});
      end
      @(posedge clock);
      sreq <= 32'h0;
      rtc_alarm_request_n <= 1'b1;
      tick(240);
      eoi <= 1'b1;
      @(posedge clock);
      eoi <= 1'b0;
      tick(2);
      #1;
      chk(intr, 0);
   endtask
   task automatic apic_case(input logic [28:0] src, input logic [31:0] scan, input logic [4:0] d);
      int n;
      logic [7:0] e;
      // third pair carries dest[4] on d0 and a released d1
      e = {2'b11, d[4], 1'b1, d[2], d[3], d[0], d[1]};
      n = 0;
      @(posedge clock);
      pci_src <= src;
      preq <= scan;
      while (!(apic_d0_oe_n === 1'b0 && apic_d1_oe_n === 1'b0) && n < 300) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(n < 300, 1);
      for (int p = 0; p < 4; p++) begin
         tick(2);
         #1;
         chk({apic_d0_oe_n, apic_d1_oe_n}, e[2 * p +: 2]);
      end
      @(posedge clock);
      pci_src <= 29'h0;
      preq <= 32'h0;
      tick(4);
   endtask
   // edges seen outside apic mode must not send
   task automatic apic_off();
      int low;
      low = 0;
      @(posedge clock);
      apic_mode <= 1'b0;
      pci_src <= 29'h1000000;
      repeat (40) begin
         @(posedge clock);
         #1;
         if (apic_d0_oe_n !== 1'b1 || apic_d1_oe_n !== 1'b1) low++;
      end
      chk(low, 0);
      @(posedge clock);
      pci_src <= 29'h0;
   endtask
   initial begin
      nrst = 1'b0;
      continuous_mode = 1'b1;
      apic_mode = 1'b1;
      rtc_alarm_request_n = 1'b1;
      intack = 1'b0;
      eoi = 1'b0;
      cfg_wr = 1'b0;
      kick = 1'b0;
      pci_src = 29'h0;
      legacy_mask = 16'h0000;
      sreq = 32'h0;
      preq = 32'h0;
      cfg_src = 5'h00;
      cfg_dest = 5'h00;
      reset_check();
      for (int i = 0; i < 29; i++) begin
         apic_case(29'h1 << i, 32'h0, 5'(16 + pmap[i]));
      end
      apic_case(29'h0, 32'h4000, 5'h1e);
      @(posedge clock);
      cfg_wr <= 1'b1;
      cfg_src <= 5'h14;
      cfg_dest <= 5'h1d;
      @(posedge clock);
      cfg_wr <= 1'b0;
      apic_case(29'h1000000, 32'h0, 5'h1d);
      // a destination below sixteen pulls d0 low in the third pair
      @(posedge clock);
      cfg_wr <= 1'b1;
      cfg_dest <= 5'h06;
      @(posedge clock);
      cfg_wr <= 1'b0;
      apic_case(29'h1000000, 32'h0, 5'h06);
      apic_off();
      reset_check();
      foreach (levels[i]) begin
         legacy_case(17'h1 << levels[i], 16'h0, 5'(levels[i]));
      end
      legacy_case(17'h00408, 16'h0000, 5'h0a);
      legacy_case(17'h00402, 16'h0000, 5'h01);
      legacy_case(17'h00024, 16'h0000, 5'h05);
      legacy_case(17'h10000, 16'h0000, 5'h08);
      legacy_case(17'h00210, 16'h0200, 5'h04);
      legacy_case(17'h00200, 16'hffff, 5'h10);
      @(posedge clock);
      continuous_mode <= 1'b0;
      kick <= 1'b1;
      legacy_case(17'h00200, 16'h0000, 5'h09);
      conclude();
   end
endmodule
`default_nettype wire
